// *** hw/ddr_pkg.sv ***
// Purpose: Shared constants for the DDR io_cell register pair block
// Assumes: One 100 MHz core clock samples both link clock pairs
// Notes:   Reset values and FIFO geometry live here
package ddr_pkg;
  localparam int        DDR_FIFO_WIDTH  = 2;
  localparam int        DDR_FIFO_DEPTH  = 16;
  localparam int        DDR_FIFO_AW     = 4;
  localparam logic      DDR_FLOP_RST    = 1'b0;
  localparam logic      DDR_BOTH_FORCE_VAL = 1'b0;
  localparam logic [1:0] DDR_SYNC_RST   = 2'h0;
endpackage

// *** hw/ddr_fifo.sv ***
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-low reset
// Notes:   Depth must be a power of two
`timescale 1ns/1ns
module ddr_fifo
  import ddr_pkg::*;
#(
  parameter int WIDTH = DDR_FIFO_WIDTH,
  parameter int DEPTH = DDR_FIFO_DEPTH,
  parameter int AW    = DDR_FIFO_AW
) (
  // Clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             reset_n_i,
  // Write side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Read side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      wr_ptr_next;
  logic [AW:0]      rd_ptr_reg;
  logic [AW:0]      rd_ptr_next;
  logic             push;
  logic             pop;

  // Full and empty from pointer difference
  assign in_ready_o  = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_ptr_reg != rd_ptr_reg;
  assign out_data_o  = mem_reg[rd_ptr_reg[AW-1:0]];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Pointer next values
  always_comb begin
    wr_ptr_next = wr_ptr_reg + (AW+1)'(push);
    rd_ptr_next = rd_ptr_reg + (AW+1)'(pop);
  end

  // Pointer and storage registers
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
    end
  end
endmodule

// *** hw/ddr_io_pair.sv ***
// Summary of operation
// R1: Cascade is used only when the pin pair is differential.
// R2: Cascade path stays between the paired cells, never on fabric ports.
// R3: Input first bit on clock a rise, second bit on clock b rise.
// R4: With cascade, second bit re-registered on clock a before delivery.
// R5: Without cascade, fabric moves both bits into one domain itself.
// R6: Output first bit on clock a rise, second bit on clock b rise.
// R7: DDR multiplexer combines both launched bits onto the output pin.
// R8: Fabric resyncs second output bit into clock b domain itself.
// R9: Alignment option unused; pair acts as plain DDR output flop.
// R10: Set/reset and reverse together force every element to zero.
// R11: Elements load only with clock enable asserted; open enable asserts.
// R12: The two clocks of each pair are complementary.
// R13: Mux shows first bit after a rise, second after b rise.
//
// Purpose: DDR input capture and output launch of one io_cell pair
// Assumes: Link clocks far slower than core clock (160 ns period)
// Notes:   Link clocks are sampled; their rises become enable pulses
`timescale 1ns/1ns
module ddr_io_pair
  import ddr_pkg::*;
(
  // Core clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       reset_n_i,
  // Configuration
  input  wire logic       differential_i,
  input  wire logic       cascade_en_i,
  // Storage element controls
  input  wire logic       set_reset_line_i,
  input  wire logic       reverse_line_i,
  input  wire logic       set_high_i,
  input  wire logic       in_clk_en_i,
  input  wire logic       out_clk_en_i,
  // Input pin and clocks
  input  wire logic       data_pin_i,
  input  wire logic       input_clock_a_i,
  input  wire logic       input_clock_b_i,
  // Captured data to fabric
  output logic            first_edge_bit_o,
  output logic            second_edge_bit_o,
  output logic            rx_valid_o,
  input  wire logic       rx_ready_i,
  // Output clocks and fabric data
  input  wire logic       output_clock_a_i,
  input  wire logic       output_clock_b_i,
  input  wire logic       tx_first_bit_i,
  input  wire logic       tx_second_bit_i,
  // Output pin
  output logic            data_pin_o
);
  // Two-flop synchronisers for pin and link clocks
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic [4:0] sync3_reg;
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else begin
      sync1_reg <= {output_clock_b_i, output_clock_a_i, input_clock_b_i,
                    input_clock_a_i, data_pin_i};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  logic din;
  logic ia_rise;
  logic ib_rise;
  logic oa_rise;
  logic ob_rise;
  assign din     = sync2_reg[0];
  assign ia_rise = sync2_reg[1] && !sync3_reg[1];
  assign ib_rise = sync2_reg[2] && !sync3_reg[2];
  assign oa_rise = sync2_reg[3] && !sync3_reg[3];
  assign ob_rise = sync2_reg[4] && !sync3_reg[4];

  // Cascade permitted only on a differential pair
  logic casc;
  assign casc = cascade_en_i && differential_i; // [R1]

  // Storage element update: forced value, load, or hold
  function automatic logic elem(input logic q, input logic d,
                                input logic ld, input logic fset,
                                input logic fflip, input logic hi);
    logic r;
    r = q;
    if (fset && fflip) begin
      r = DDR_BOTH_FORCE_VAL; // [R10]
    end else if (fset) begin
      r = hi;
    end else if (fflip) begin
      r = !hi;
    end else if (ld) begin
      r = d; // [R11]
    end
    return r;
  endfunction

  // Input, cascade slave and output element state
  logic in_a_reg, in_a_next, in_b_reg, in_b_next;
  logic slv_reg, slv_next, out_a_reg, out_a_next;
  logic out_b_reg, out_b_next, mux_reg, mux_next;
  logic push_reg, push_next;
  logic force_set;
  logic force_flip;
  logic ice;
  logic oce;
  assign force_set  = set_reset_line_i;
  assign force_flip = reverse_line_i;
  assign ice = in_clk_en_i;
  assign oce = out_clk_en_i;

  // Next-state of all storage elements and DDR mux
  always_comb begin
    in_a_next  = elem(in_a_reg, din, ia_rise && ice, force_set,
                      force_flip, set_high_i); // [R3]
    in_b_next  = elem(in_b_reg, din, ib_rise && ice, force_set,
                      force_flip, set_high_i); // [R3]
    slv_next   = elem(slv_reg, in_b_reg, ia_rise && ice, force_set,
                      force_flip, set_high_i); // [R4]
    out_a_next = elem(out_a_reg, tx_first_bit_i, oa_rise && oce,
                      force_set, force_flip, set_high_i); // [R6]
    out_b_next = elem(out_b_reg, tx_second_bit_i, ob_rise && oce,
                      force_set, force_flip, set_high_i); // [R6] [R9]
    mux_next   = mux_reg;
    if (oa_rise) begin
      mux_next = out_a_next; // [R7] [R13]
    end else if (ob_rise) begin
      mux_next = out_b_next; // [R7] [R13]
    end
    push_next  = ia_rise && ice;
  end

  // Register all storage elements, mux and push strobe
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      in_a_reg  <= DDR_FLOP_RST;
      in_b_reg  <= DDR_FLOP_RST;
      slv_reg   <= DDR_FLOP_RST;
      out_a_reg <= DDR_FLOP_RST;
      out_b_reg <= DDR_FLOP_RST;
      mux_reg   <= DDR_FLOP_RST;
      push_reg  <= 1'b0;
    end else begin
      in_a_reg  <= in_a_next;
      in_b_reg  <= in_b_next;
      slv_reg   <= slv_next;
      out_a_reg <= out_a_next;
      out_b_reg <= out_b_next;
      mux_reg   <= mux_next;
      push_reg  <= push_next;
    end
  end

  // Pin driven from the DDR mux flop
  assign data_pin_o = mux_reg; // [R7]

  // Word to fabric: cascade delivers the slave bit, else raw second bit
  logic [1:0] word;
  logic       ff_valid;
  logic [1:0] ff_data;
  logic       ff_take;
  assign word = {casc ? slv_reg : in_b_reg, in_a_reg}; // [R2] [R4] [R5]

  ddr_fifo #(
    .WIDTH (DDR_FIFO_WIDTH),
    .DEPTH (DDR_FIFO_DEPTH),
    .AW    (DDR_FIFO_AW)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (push_reg),
    .in_ready_o  (),
    .in_data_i   (word),
    .out_valid_o (ff_valid),
    .out_ready_i (ff_take),
    .out_data_o  (ff_data)
  );

  // Output stage register so fabric outputs come from flops
  logic [1:0] rx_reg, rx_next;
  logic       rxv_reg, rxv_next;
  assign ff_take = ff_valid && (!rxv_reg || rx_ready_i);
  always_comb begin
    rx_next  = rx_reg;
    rxv_next = rxv_reg && !rx_ready_i;
    if (ff_take) begin
      rx_next  = ff_data;
      rxv_next = 1'b1;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      rx_reg  <= DDR_SYNC_RST;
      rxv_reg <= 1'b0;
    end else begin
      rx_reg  <= rx_next;
      rxv_reg <= rxv_next;
    end
  end
  assign first_edge_bit_o  = rx_reg[0];
  assign second_edge_bit_o = rx_reg[1];
  assign rx_valid_o        = rxv_reg;

  // Checks
  chk_force_both_zero: assert property (@(posedge core_clk_i) // [R10]
    disable iff (!reset_n_i) (force_set && force_flip)
    |=> !in_a_reg && !out_b_reg)
    else $error("set/reset with reverse did not clear");
  chk_capture_a: assert property (@(posedge core_clk_i) // [R3]
    disable iff (!reset_n_i) (ia_rise && ice && !force_set && !force_flip)
    |=> in_a_reg == $past(din))
    else $error("first bit not captured");
  chk_hold_ce: assert property (@(posedge core_clk_i) // [R11]
    disable iff (!reset_n_i) (!ice && !force_set && !force_flip)
    |=> $stable(in_b_reg))
    else $error("element loaded without enable");
  chk_cascade_path: assert property (@(posedge core_clk_i) // [R4]
    disable iff (!reset_n_i) (ia_rise && ice && !force_set && !force_flip)
    |=> slv_reg == $past(in_b_reg))
    else $error("slave not reloaded");
  chk_cascade_gate: assert property (@(posedge core_clk_i) // [R1]
    disable iff (!reset_n_i) !differential_i |-> word[1] == in_b_reg)
    else $error("cascade used on single-ended pin");
  chk_launch_b: assert property (@(posedge core_clk_i) // [R6]
    disable iff (!reset_n_i) (ob_rise && oce && !force_set && !force_flip)
    |=> out_b_reg == $past(tx_second_bit_i))
    else $error("b not launched");
  chk_mux_a: assert property (@(posedge core_clk_i) // [R13]
    disable iff (!reset_n_i) oa_rise |=> data_pin_o == out_a_reg)
    else $error("pin not first bit");
  chk_mux_b: assert property (@(posedge core_clk_i) // [R7]
    disable iff (!reset_n_i) (ob_rise && !oa_rise)
    |=> data_pin_o == out_b_reg)
    else $error("pin not second bit");
endmodule

// *** bench/ddr_link_model.sv ***
// Purpose: Far-side DDR source and sink on the link pins
// Assumes: 16 core cycles make one 160 ns link clock period
// Notes:   Link clocks stand still low between frames
`timescale 1ns/1ns
module ddr_link_model (
  // Pacing clock
  input  wire logic core_clk_i,
  // Source side
  output logic      in_clk_a_o,
  output logic      in_clk_b_o,
  output logic      pin_o,
  // Sink side
  output logic      out_clk_a_o,
  output logic      out_clk_b_o,
  input  wire logic pin_i
);
  // Idle levels at time zero
  initial begin
    in_clk_a_o  <= 1'b0;
    in_clk_b_o  <= 1'b0;
    out_clk_a_o <= 1'b0;
    out_clk_b_o <= 1'b0;
    pin_o       <= 1'b0;
  end
  // One period: a rises mid first bit, b rises mid second
  task automatic send_pair(input logic bit_a, input logic bit_b);
    pin_o <= bit_a;
    repeat (4) @(posedge core_clk_i);
    in_clk_a_o <= 1'b1;
    in_clk_b_o <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    pin_o <= bit_b;
    repeat (4) @(posedge core_clk_i);
    in_clk_a_o <= 1'b0;
    in_clk_b_o <= 1'b1;
    repeat (4) @(posedge core_clk_i);
  endtask
  // Frame end: clocks stop, released data line flips
  task automatic end_frame();
    in_clk_b_o  <= 1'b0;
    out_clk_b_o <= 1'b0;
    pin_o       <= ~pin_o;
    @(posedge core_clk_i);
  endtask
  // Plain DDR sink, no alignment option; samples six cycles into each eight-cycle half
  task automatic get_pair(output logic g1, output logic g2);
    out_clk_a_o <= 1'b1;
    out_clk_b_o <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    g1 = pin_i;
    repeat (2) @(posedge core_clk_i);
    out_clk_a_o <= 1'b0;
    out_clk_b_o <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    g2 = pin_i;
    repeat (2) @(posedge core_clk_i);
  endtask
endmodule

// *** bench/ddr_io_pair_tb_top.sv ***
// Purpose: Self-checking bench for the DDR io_cell pair
// Assumes: Words pair the a bit with the b element held at a rise
// Notes:   Fabric side stalls to fill the FIFO, then drains it
`timescale 1ns/1ns
module ddr_io_pair_tb_top;
  import ddr_pkg::*;
  logic clk, rst_n, diff, casc, set_rst, flip_line, hi;
  logic in_en, out_en, rdy, tx1, tx2;
  logic [1:0] want;
  logic ica, icb, oca, ocb, pin_in, pin_out, b1, b2, vld, last_b, g1, g2;
  logic [1:0] exp_q[$];
  int         num_errors = 0;
  int         checks_done = 0;
  int         cycles = 0;
  ddr_io_pair u_dut (.core_clk_i(clk), .reset_n_i(rst_n),
    .differential_i(diff), .cascade_en_i(casc),
    .set_reset_line_i(set_rst), .reverse_line_i(flip_line),
    .set_high_i(hi), .in_clk_en_i(in_en),
    .out_clk_en_i(out_en), .data_pin_i(pin_in), .input_clock_a_i(ica),
    .input_clock_b_i(icb), .first_edge_bit_o(b1), .second_edge_bit_o(b2),
    .rx_valid_o(vld), .rx_ready_i(rdy), .output_clock_a_i(oca),
    .output_clock_b_i(ocb), .tx_first_bit_i(tx1), .tx_second_bit_i(tx2),
    .data_pin_o(pin_out));
  ddr_link_model u_link (.core_clk_i(clk), .in_clk_a_o(ica),
    .in_clk_b_o(icb), .pin_o(pin_in), .out_clk_a_o(oca),
    .out_clk_b_o(ocb), .pin_i(pin_out));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Accepted words in the a domain against expectations, plus timeout
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (rst_n && vld === 1'b1 && rdy === 1'b1) begin
      want = exp_q.size() ? exp_q.pop_front() : 2'hx;
      check(8'({b2, b1}), 8'(want));
    end
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  // Sends n pairs and records the words they should make
  task automatic frame(input int n, input logic [31:0] f,
                       input logic [31:0] s);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back({last_b, f[i]});
      u_link.send_pair(f[i], s[i]);
      last_b = s[i];
    end
    u_link.end_frame();
  endtask
  // Fabric accepts for 60 cycles, then nothing must be left
  task automatic drain();
    rdy <= 1'b1;
    repeat (60) @(posedge clk);
    check(8'(exp_q.size()), 8'h0);
  endtask
  // Every pin-standard and cascade setting
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      diff <= m[0];
      casc <= m[1];
      frame(4, 32'h5 ^ m, 32'h9 ^ (m << 1));
      drain();
    end
  endtask
  // Fabric stalls while the FIFO fills to its depth
  task automatic t_fill();
    rdy <= 1'b0;
    frame(DDR_FIFO_DEPTH + 1, 32'h3c5a, 32'h96e1);
    check(8'(vld), 8'h1);
    drain();
  endtask
  // Set, reverse and both together on the b element
  task automatic t_force();
    hi <= 1'b1;
    for (int k = 1; k < 4; k++) begin
      frame(1, 32'h0, 32'h1);
      set_rst   <= k[0];
      flip_line <= k[1];
      repeat (3) @(posedge clk);
      set_rst   <= 1'b0;
      flip_line <= 1'b0;
      last_b = (k == 1);
      frame(1, 32'h1, 32'h0);
      drain();
    end
  endtask
  // Input enable low: no word, b element keeps its old bit
  task automatic t_in_hold();
    in_en <= 1'b0;
    u_link.send_pair(1'b1, ~last_b);
    u_link.end_frame();
    in_en <= 1'b1;
    frame(1, 32'h0, 32'h0);
    drain();
  endtask
  // Output launch, then enable low keeps the old pair
  task automatic t_out();
    for (int k = 0; k < 4; k++) begin
      tx1 <= k[0];
      tx2 <= k[1]; // held all period for the b domain
      u_link.get_pair(g1, g2);
      check(8'({g2, g1}), 8'(k));
    end
    out_en <= 1'b0;
    tx1    <= 1'b0;
    tx2    <= 1'b0;
    u_link.get_pair(g1, g2);
    check(8'({g2, g1}), 8'h3);
    out_en <= 1'b1;
    u_link.end_frame();
  endtask
  // Main sequence
  initial begin
    {rst_n, diff, casc, set_rst, flip_line, hi, tx1, tx2, rdy} <= '0;
    {in_en, out_en} <= 2'h3;
    last_b = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_modes();
    t_fill();
    t_force();
    t_in_hold();
    t_out();
    tally_and_finish();
  end
endmodule
